// ### hw/logic_tile_cfg.svh
// Contract
// - one 8-bit alu result every cycle
// - accumulators are alu sources and sinks
// - operand registers feed alu, never written by it (bus only)
// - two four-byte queues load or capture
// - bus reads and writes six working registers
// - eight 16-bit config words select operation
// - inc dec add sub and or xor pass
// - shift, swap and or-mask after alu
// - two masked comparators, second one with selectable operand pair
// - zero, ones, overflow; selectable routed outputs
// - programmable msb for arithmetic and shift
// - crc or prs step each cycle, chainable
// - each queue input or output buffer
// - queue status selectable as outputs
// - carry, shift, conditions chain to neighbours
// - carry and shift out registered, reusable
// - six routing inputs and six outputs
// - control bits drive the eight ctrl_out outputs
// - status register read-only from routing
// - sticky status bit cleared on read
// - separate enables for datapath and status capture
`ifndef LOGIC_TILE_CFG_SVH
`define LOGIC_TILE_CFG_SVH
`define ADDR_ACC0 8'h00
`define ADDR_ACC1 8'h04
`define ADDR_OPR0 8'h08
`define ADDR_OPR1 8'h0C
`define ADDR_Q0 8'h10
`define ADDR_Q1 8'h14
`define ADDR_CTRL 8'h18
`define ADDR_STAT 8'h1C
`define ADDR_STKMSK 8'h20
`define ADDR_MASK 8'h24
`define ADDR_POLY 8'h28
`define ADDR_CMPMSK 8'h2C
`define ADDR_OUTSEL 8'h30
`define ADDR_MISC 8'h34
`define ADDR_CFG_BASE 8'h40
`define ADDR_CFG_TOP 8'h5C
`define Q_DEPTH 4
`endif

// ### hw/logic_tile_pkg.sv
package logic_tile_pkg;
  typedef enum logic [2:0] {op_pass, op_inc, op_dec, op_add, op_sub, op_and, op_or, op_xor} alu_op_e;
  typedef enum logic [1:0] {sh_none, sh_left, sh_right, sh_swap} shift_e;
  // config word: [15:13] op, [12:11] src a, [10:9] src b, [8:7] shift,
  // [6] dest acc1, [5] write enable, [4] queue0 load, [3] queue1 load,
  // [2] or-mask enable, [1] crc mode, [0] carry from registered carry
  typedef struct packed {
    alu_op_e op;
    logic [1:0] src_a;
    logic [1:0] src_b;
    shift_e shift;
    logic dest1;
    logic wr_en;
    logic q0_ld;
    logic q1_ld;
    logic mask_en;
    logic crc;
    logic cy_reg;
  } cfg_word_s;
endpackage : logic_tile_pkg

// ### hw/logic_tile.sv
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "logic_tile_cfg.svh"
module logic_tile
  import logic_tile_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic [5:0] route_in,
  output logic [5:0] route_out,
  output logic [7:0] ctrl_out,
  input wire logic carry_in_chain,
  input wire logic shift_in_chain,
  input wire logic cond_in_chain,
  output logic carry_out_chain,
  output logic shift_out_chain,
  output logic cond_out_chain
);
  typedef struct packed {
    logic [7:0] acc0;
    logic [7:0] acc1;
    logic [7:0] opr0;
    logic [7:0] opr1;
    logic [1:0][3:0][7:0] qmem;
    logic [1:0][1:0] wp;
    logic [1:0][1:0] rp;
    logic [1:0][2:0] cnt;
    logic [7:0] ctrl;
    logic [7:0] sticky;
    logic [7:0] stk_mask;
    logic [7:0] out_mask;
    logic [7:0] poly;
    logic [7:0] cmp_mask;
    logic [7:0] out_sel;
    logic [7:0] misc;
    logic [7:0][15:0] cfg;
    logic carry_r;
    logic shift_r;
    logic [7:0] rdata;
    logic [5:0] route_out;
    logic cy_o;
    logic sh_o;
    logic cd_o;
  } state_s;
  state_s s_reg;
  state_s s_next;
  cfg_word_s cw;
  logic [7:0] a;
  logic [7:0] b;
  logic [8:0] sum;
  logic [7:0] alu;
  logic [7:0] shv;
  logic [7:0] res;
  logic [7:0] msb_bit;
  logic [7:0] keep;
  logic cin;
  logic sin;
  logic msb_out;
  logic ovf;
  logic cmp0_eq;
  logic cmp0_lt;
  logic cmp1_eq;
  logic [11:0] conds;
  logic [7:0] status;
  logic dp_en;
  logic sc_en;
  logic [1:0] q_empty;
  logic [1:0] q_full;
  logic [1:0] q_dir_out;
  logic [1:0] q_push;
  logic [1:0] q_pop;
  logic [1:0][7:0] q_din;
  logic [1:0][7:0] q_head;
  logic [2:0] msb_pos;
  logic [7:0] bus_rd;
  logic [7:0] b_eff;
  logic a_top;
  logic b_top;
  logic r_top;
  logic cy_msb;
  logic fb;
  logic cfg_hit;
  logic cfg_hi;
  logic [2:0] cfg_idx;

  genvar gq;
  generate
    for (gq = 0; gq < 2; gq++)
    begin : g_q
      assign q_empty[gq] = (s_reg.cnt[gq] == 3'h0);
      assign q_full[gq] = (s_reg.cnt[gq] == 3'(`Q_DEPTH));
      assign q_head[gq] = s_reg.qmem[gq][s_reg.rp[gq]];
    end
  endgenerate

  // config ram window: low byte on even half-word, high byte on odd
  always_comb
  begin
    cfg_hit = (addr >= `ADDR_CFG_BASE) && (addr <= (`ADDR_CFG_TOP + 8'h03));
    cfg_hi = addr[1];
    cfg_idx = addr[4:2];
  end

  always_comb
  begin
    dp_en = s_reg.misc[0];
    sc_en = s_reg.misc[1];
    q_dir_out = s_reg.misc[3:2];
    msb_pos = s_reg.misc[6:4];
    cw = cfg_word_s'(s_reg.cfg[route_in[2:0]]);
    sin = route_in[3] | shift_in_chain;
    cin = cw.cy_reg ? s_reg.carry_r : carry_in_chain;

    // operand a may also come straight off a queue head
    unique case (cw.src_a)
      2'h0: a = s_reg.acc0;
      2'h1: a = s_reg.acc1;
      2'h2: a = q_head[0];
      2'h3: a = q_head[1];
    endcase
    unique case (cw.src_b)
      2'h0: b = s_reg.opr0;
      2'h1: b = s_reg.opr1;
      2'h2: b = s_reg.acc0;
      2'h3: b = s_reg.acc1;
    endcase

    sum = 9'h000;
    unique case (cw.op)
      op_pass: sum = {1'b0, a};
      op_inc: sum = {1'b0, a} + 9'h001;
      op_dec: sum = {1'b0, a} - 9'h001;
      op_add: sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      op_sub: sum = {1'b0, a} - {1'b0, b};
      op_and: sum = {1'b0, a & b};
      op_or: sum = {1'b0, a | b};
      op_xor: sum = {1'b0, a ^ b};
    endcase

    // every arithmetic flag is taken at the programmed top bit
    msb_bit = 8'h01 << msb_pos;
    keep = (msb_bit << 1) - 8'h01;
    alu = sum[7:0];
    cy_msb = sum[4'(msb_pos) + 4'h1];
    b_eff = (cw.op == op_sub) ? ~b : b;
    a_top = (a & msb_bit) != 8'h00;
    b_top = (b_eff & msb_bit) != 8'h00;
    r_top = (sum[7:0] & msb_bit) != 8'h00;
    // signed overflow: like-signed operands giving an unlike-signed result
    ovf = 1'b0;
    if (cw.op == op_add || cw.op == op_sub)
    begin
      ovf = (a_top == b_top) && (r_top != a_top);
    end
    msb_out = a_top;

    // crc step folds in poly when top bit and serial in differ
    fb = msb_out ^ sin;
    if (cw.crc)
    begin
      alu = ((a << 1) & keep) ^ (fb ? (s_reg.poly & keep) : 8'h00);
    end

    unique case (cw.shift)
      sh_none: shv = alu;
      sh_left: shv = ((alu << 1) | {7'h00, sin}) & keep;
      sh_right: shv = (alu >> 1) | (sin ? msb_bit : 8'h00);
      sh_swap: shv = {alu[3:0], alu[7:4]};
    endcase
    res = cw.mask_en ? (shv | s_reg.out_mask) : shv;

    // both comparators share one mask register
    cmp0_eq = ((s_reg.acc0 ^ s_reg.opr0) & s_reg.cmp_mask) == 8'h00;
    cmp0_lt = (s_reg.acc0 & s_reg.cmp_mask) < (s_reg.opr0 & s_reg.cmp_mask);
    // second comparator pairing chosen by misc[7]
    if (s_reg.misc[7])
    begin
      cmp1_eq = ((s_reg.acc1 ^ s_reg.opr1) & s_reg.cmp_mask) == 8'h00;
    end
    else
    begin
      cmp1_eq = ((s_reg.acc0 ^ s_reg.acc1) & s_reg.cmp_mask) == 8'h00;
    end

    // condition vector, lowest index first
    conds[0] = cmp0_eq & cond_in_chain;
    conds[1] = cmp0_lt;
    conds[2] = cmp1_eq;
    conds[3] = s_reg.acc0 == 8'h00;
    conds[4] = s_reg.acc1 == 8'h00;
    conds[5] = s_reg.acc0 == 8'hFF;
    conds[6] = s_reg.acc1 == 8'hFF;
    conds[7] = ovf;
    conds[9:8] = q_empty;
    conds[11:10] = q_full;
    status = {route_in[5:4], conds[5:0]};
  end

  always_comb
  begin
    s_next = s_reg;
    q_push = 2'b00;
    q_pop = 2'b00;
    q_din = '0;
    bus_rd = 8'h00;

    // one datapath step per enabled clock
    if (dp_en)
    begin
      if (cw.wr_en)
      begin
        if (cw.dest1)
          s_next.acc1 = res;
        else
          s_next.acc0 = res;
      end
      s_next.carry_r = cy_msb;
      s_next.shift_r = msb_out;
      s_next.cy_o = cy_msb;
      s_next.sh_o = (cw.shift == sh_right) ? alu[0] : msb_out;
      s_next.cd_o = cmp0_eq;
      for (int q = 0; q < 2; q++)
      begin
        if ((q == 0 ? cw.q0_ld : cw.q1_ld))
        begin
          if (q_dir_out[q])
          begin
            q_push[q] = 1'b1;
            q_din[q] = (q == 0) ? res : s_reg.acc1;
          end
          else if (!q_empty[q])
          begin
            q_pop[q] = 1'b1;
            if (q == 0)
              s_next.acc0 = q_head[q];
            else
              s_next.acc1 = q_head[q];
          end
        end
      end
    end

    // status capture runs on its own enable
    if (sc_en)
    begin
      s_next.sticky = s_reg.sticky | (status & s_reg.stk_mask);
    end

    // reads only pop a queue or reload the sticky bits
    if (rd_stb)
    begin
      if (cfg_hit)
      begin
        if (cfg_hi)
          bus_rd = s_reg.cfg[cfg_idx][15:8];
        else
          bus_rd = s_reg.cfg[cfg_idx][7:0];
      end
      unique case (addr)
        `ADDR_ACC0: bus_rd = s_reg.acc0;
        `ADDR_ACC1: bus_rd = s_reg.acc1;
        `ADDR_OPR0: bus_rd = s_reg.opr0;
        `ADDR_OPR1: bus_rd = s_reg.opr1;
        `ADDR_Q0, `ADDR_Q1:
        begin
          if (q_dir_out[addr[2]] && !q_empty[addr[2]])
          begin
            bus_rd = q_head[addr[2]];
            q_pop[addr[2]] = 1'b1;
          end
        end
        `ADDR_CTRL: bus_rd = s_reg.ctrl;
        `ADDR_STAT:
        begin
          bus_rd = (status & ~s_reg.stk_mask) | s_reg.sticky;
          s_next.sticky = status & s_reg.stk_mask; // set wins over clear
        end
        `ADDR_STKMSK: bus_rd = s_reg.stk_mask;
        `ADDR_MASK: bus_rd = s_reg.out_mask;
        `ADDR_POLY: bus_rd = s_reg.poly;
        `ADDR_CMPMSK: bus_rd = s_reg.cmp_mask;
        `ADDR_OUTSEL: bus_rd = s_reg.out_sel;
        `ADDR_MISC: bus_rd = s_reg.misc;
        default: ;
      endcase
    end

    // bus write lands after the datapath step, so software wins a clash
    if (wr_stb)
    begin
      if (cfg_hit)
      begin
        if (cfg_hi)
          s_next.cfg[cfg_idx][15:8] = wdata;
        else
          s_next.cfg[cfg_idx][7:0] = wdata;
      end
      unique case (addr)
        `ADDR_ACC0: s_next.acc0 = wdata;
        `ADDR_ACC1: s_next.acc1 = wdata;
        `ADDR_OPR0: s_next.opr0 = wdata;
        `ADDR_OPR1: s_next.opr1 = wdata;
        `ADDR_Q0, `ADDR_Q1:
        begin
          if (!q_dir_out[addr[2]])
          begin
            q_push[addr[2]] = 1'b1;
            q_din[addr[2]] = wdata;
          end
        end
        `ADDR_CTRL: s_next.ctrl = wdata;
        `ADDR_STKMSK: s_next.stk_mask = wdata;
        `ADDR_MASK: s_next.out_mask = wdata;
        `ADDR_POLY: s_next.poly = wdata;
        `ADDR_CMPMSK: s_next.cmp_mask = wdata;
        `ADDR_OUTSEL: s_next.out_sel = wdata;
        `ADDR_MISC: s_next.misc = wdata;
        default: ;
      endcase
    end

    for (int q = 0; q < 2; q++)
    begin
      // full push is dropped, contents kept
      if (q_push[q] && !q_full[q])
      begin
        s_next.qmem[q][s_reg.wp[q]] = q_din[q];
        s_next.wp[q] = s_reg.wp[q] + 2'h1;
      end
      if (q_pop[q] && !q_empty[q])
        s_next.rp[q] = s_reg.rp[q] + 2'h1;
      s_next.cnt[q] = s_reg.cnt[q] + 3'(q_push[q] && !q_full[q]) - 3'(q_pop[q] && !q_empty[q]);
    end

    s_next.rdata = bus_rd;
    // two banks of six selectable condition outputs
    if (s_reg.out_sel[0])
    begin
      s_next.route_out = conds[11:6];
    end
    else
    begin
      s_next.route_out = conds[5:0];
    end
    if (s_reg.out_sel[1])
    begin
      s_next.route_out[5] = s_reg.shift_r; // serial data out
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // every output is a flop of the state struct
  assign rdata = s_reg.rdata;
  assign route_out = s_reg.route_out;
  assign ctrl_out = s_reg.ctrl;
  assign carry_out_chain = s_reg.cy_o;
  assign shift_out_chain = s_reg.sh_o;
  assign cond_out_chain = s_reg.cd_o;
endmodule : logic_tile

// ### dv/logic_tile_checker.sv
`timescale 1ns/1ps
`include "logic_tile_cfg.svh"
module logic_tile_checker
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic [5:0] route_out,
  input wire logic [7:0] ctrl_out,
  input wire logic carry_out_chain,
  input wire logic shift_out_chain,
  input wire logic cond_out_chain
);
  // shadows of misc[0] and outsel[0], rebuilt from bus writes
  logic dp_en_reg;
  logic osel_reg;
  logic wr_ctl;
  assign wr_ctl = wr_stb && addr == `ADDR_CTRL;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dp_en_reg <= 1'b0;
      osel_reg <= 1'b0;
    end
    else if (wr_stb && addr == `ADDR_MISC)
      dp_en_reg <= wdata[0];
    else if (wr_stb && addr == `ADDR_OUTSEL)
      osel_reg <= wdata[0];
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  property p_rd_idle;
    !rd_stb |=> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_unmapped;
    rd_stb && addr == 8'h38 |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_acc_rw;
    (wr_stb && addr == `ADDR_ACC0 && !dp_en_reg) ##1 (rd_stb && addr == `ADDR_ACC0)
      |=> rdata == $past(wdata, 2);
  endproperty
  a_acc_rw: assert property (p_acc_rw) else $error("acc readback");
  property p_ctl_wr;
    wr_ctl |=> ctrl_out == $past(wdata);
  endproperty
  a_ctl_wr: assert property (p_ctl_wr) else $error("ctrl write");
  property p_ctl_hold;
    !wr_ctl |=> $stable(ctrl_out);
  endproperty
  a_ctl_hold: assert property (p_ctl_hold) else $error("ctrl moved");
  property p_chain_hold;
    !dp_en_reg |=> $stable({carry_out_chain, shift_out_chain, cond_out_chain});
  endproperty
  a_chain_hold: assert property (p_chain_hold) else $error("chain moved");
  property p_rst_vals;
    $rose(resetn) |-> ctrl_out == 8'h00 && route_out == 6'h00;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset value");
  property p_zero_det;
    (wr_stb && addr == `ADDR_ACC0 && !dp_en_reg && !osel_reg)
      ##1 (!(wr_stb && (addr == `ADDR_ACC0 || addr == `ADDR_MISC || addr == `ADDR_OUTSEL)))[*2]
      |-> route_out[3] == ($past(wdata, 2) == 8'h00);
  endproperty
  a_zero_det: assert property (p_zero_det) else $error("zero detect");
endmodule : logic_tile_checker

// ### dv/route_partner.sv
`timescale 1ns/1ps
module route_partner
(
  input wire logic ref_clk,
  input wire logic [2:0] sel,
  input wire logic [1:0] stat,
  output logic [5:0] route_in,
  output logic carry_in_chain,
  output logic shift_in_chain,
  output logic cond_in_chain
);
  // carry held low so add results stay predictable
  initial
  begin
    route_in = 6'h00;
    carry_in_chain = 1'b0;
    shift_in_chain = 1'b0;
    cond_in_chain = 1'b0;
  end
  always @(posedge ref_clk)
  begin
    route_in <= {stat, 1'($urandom), sel};
    shift_in_chain <= 1'($urandom);
    cond_in_chain <= 1'($urandom);
  end
endmodule : route_partner

// ### dv/tb_configurable_datapath_with_status_ctrl.sv
`timescale 1ns/1ps
`include "logic_tile_cfg.svh"
module tb_configurable_datapath_with_status_ctrl;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rdata;
  logic [5:0] route_in;
  logic [5:0] route_out;
  logic [7:0] ctrl_out;
  logic cy_i;
  logic sh_i;
  logic cd_i;
  logic cy_o;
  logic so;
  logic cd_o;
  logic [2:0] sel = 3'h0;
  logic [1:0] stat = 2'h0;
  logic [7:0] v;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #25 ref_clk = ~ref_clk;
  logic_tile DUT (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .route_in(route_in),
    .route_out(route_out), .ctrl_out(ctrl_out), .carry_in_chain(cy_i),
    .shift_in_chain(sh_i), .cond_in_chain(cd_i), .carry_out_chain(cy_o),
    .shift_out_chain(so), .cond_out_chain(cd_o));
  route_partner far (.ref_clk(ref_clk), .sel(sel), .stat(stat), .route_in(route_in),
    .carry_in_chain(cy_i), .shift_in_chain(sh_i), .cond_in_chain(cd_i));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    wr_stb <= 1'b0;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata & m, exp);
  endtask : rd
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
    end
    #1;
  endtask : idle
  // ops 0-7 on equal operands, then shift left, swap, shift right
  function automatic logic [7:0] exp_alu(input int k, input logic [7:0] x);
    case (k)
      1: return x + 8'h01;
      2: return x - 8'h01;
      3: return x + x;
      4: return 8'h00;
      7: return 8'h00;
      8: return {x[6:0], 1'b0};
      9: return {x[3:0], x[7:4]};
      10: return {1'b0, x[7:1]};
      default: return x;
    endcase
  endfunction : exp_alu
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      stop_test();
    end
  end
  initial
  begin
    v = $urandom(32'h2dbe);
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      v = (i < 4) ? 8'h00 : $urandom;
      wr(8'(4 * (i % 4)), v);
      rd(8'(4 * (i % 4)), 8'hff, v);
    end
    wr(8'h38, 8'h5a);
    rd(8'h38, 8'hff, 8'h00);
    v = $urandom;
    wr(`ADDR_CTRL, v);
    idle(1);
    chk(ctrl_out, v);
    stat <= 2'b11;
    wr(`ADDR_MISC, 8'h02);
    wr(`ADDR_STKMSK, 8'h80);
    idle(3);
    stat <= 2'b00;
    idle(3);
    rd(`ADDR_STAT, 8'h80, 8'h80);
    rd(`ADDR_STAT, 8'h80, 8'h00);
    wr(`ADDR_OUTSEL, 8'h01);
    for (int i = 0; i < 5; i++)
      wr(`ADDR_Q0, 8'(8'h10 + i));
    idle(3);
    chk({2'b00, route_out & 6'h1c}, 8'h18);
    wr(8'h40, 8'h10);
    wr(`ADDR_MISC, 8'h71);
    idle(8);
    wr(`ADDR_MISC, 8'h70);
    idle(3);
    chk({2'b00, route_out & 6'h1c}, 8'h0c);
    rd(`ADDR_ACC0, 8'hff, 8'h13);
    wr(`ADDR_OUTSEL, 8'h00);
    sel <= 3'd3;
    wr(`ADDR_CMPMSK, 8'hff);
    for (int k = 0; k < 11; k++)
    begin
      v = $urandom;
      wr(8'h4c, (k == 8) ? 8'ha0 : (k == 9) ? 8'ha0 : 8'h20);
      wr(8'h4e, (k < 8) ? 8'(k << 5) : (k == 8) ? 8'h00 : 8'h01);
      for (int r = 0; r < 4; r++)
        wr(8'(4 * r), v);
      wr(`ADDR_MISC, 8'h71);
      wr(`ADDR_MISC, 8'h70);
      rd(`ADDR_ACC0, (k == 8) ? 8'hfe : (k == 10) ? 8'h7f : 8'hff,
        exp_alu(k, v) & ((k == 8) ? 8'hfe : (k == 10) ? 8'h7f : 8'hff));
      rd(`ADDR_OPR0, 8'hff, v);
      if (k == 3)
        chk({7'h00, cy_o}, {7'h00, v[7]});
      chk({6'h00, so, cd_o}, {6'h00, (k == 10) ? v[0] : v[7], 1'b1});
    end
    idle(2);
    stop_test();
  end
endmodule : tb_configurable_datapath_with_status_ctrl
bind logic_tile logic_tile_checker chk_i (.ref_clk(ref_clk), .resetn(resetn),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .route_out(route_out), .ctrl_out(ctrl_out), .carry_out_chain(carry_out_chain),
  .shift_out_chain(shift_out_chain), .cond_out_chain(cond_out_chain));
